// >>> shared/adc_port_consts.svh
// Notes on behaviour
// - serial clock times conversion and all transfer
// - chip select fall starts, holds, drives output
// - sixteen clocks complete one frame
// - sampler returns to track at rise 14
// - output floats at falling edge 16
// - early chip select rise aborts, floats output
// - input bits sampled on serial clock falls
// - first three input bits select register
// - control register loads at rise 15
// - sequence or range loads at fall 11
// - each output bit shifts on a fall
// - word is zero, channel, sign, result
// - leading zero appears at chip select fall
// - first channel bit at first fall
// - host captures output on falls, msb first
// - host frames every word with chip select
// - host spaces frames by whole clock periods
// - register written only when write bit set
// - host waits quiet time before next frame
`ifndef ADC_PORT_CONSTS_SVH
`define ADC_PORT_CONSTS_SVH

// frame timing, in serial clock edges
`define FRAME_EDGES 5'h10
`define TRACK_RISE 5'h0e
`define CTRL_LOAD_RISE 5'h0f
`define SR_LOAD_FALL 5'h0b

// command word fields
`define SEL_HI 15
`define SEL_LO 13
`define WE_BIT 12
`define SEL_CTRL 3'h0
`define SEL_RANGE 3'h1
`define SEL_SEQ 3'h3

// register reset values and channel field in control
`define CTRL_RESET 12'h000
`define SR_RESET 7'h00
`define CHAN_HI 11
`define CHAN_LO 10

// host register offsets
`define CMD_OFS 8'h00
`define RXD_OFS 8'h04
`define STAT_OFS 8'h08
`define STAT_BUSY 0
`define STAT_DONE 1

// host timing
`define CLK_NS 10
`define SCLK_HALF 8
`define QUIET_NS 50
`define QUIET_CYC ((`QUIET_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// >>> shared/adc_port_pkg.sv
package adc_port_pkg;

  // device frame state
  typedef enum logic [1:0] {
    D_IDLE = 2'b01,
    D_FRAME = 2'b10
  } dev_state_type;

  // host link state
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_FRAME = 3'b010,
    H_QUIET = 3'b100
  } host_state_type;

  // all device state
  typedef struct packed {
    logic [2:0] sclk_sync;
    logic [2:0] cs_sync;
    logic [2:0] din_sync;
    logic sclk_f;
    logic cs_f;
    logic din_f;
    dev_state_type state;
    logic [4:0] rise_cnt;
    logic [4:0] fall_cnt;
    logic [15:0] rx;
    logic [15:0] tx;
    logic dout;
    logic dout_oe;
    logic hold;
    logic abort;
    logic [11:0] ctrl;
    logic [6:0] seq;
    logic [6:0] rng;
  } dev_regs_type;

  // all host state
  typedef struct packed {
    logic [2:0] dout_sync;
    logic dout_f;
    host_state_type state;
    logic [7:0] div;
    logic [7:0] quiet;
    logic sclk;
    logic cs_n;
    logic din;
    logic [4:0] bit_cnt;
    logic [15:0] cmd;
    logic [15:0] rx;
    logic [15:0] rxd;
    logic done;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } host_regs_type;

endpackage

// >>> shared/adc_link_if.sv
interface adc_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  logic dout_line;

  // released output line idles high, as with a weak pull-up
  assign dout_line = dout_oe ? dout : 1'b1;

  modport dev (
    input cs_n,
    input sclk,
    input din,
    output dout,
    output dout_oe
  );

  modport host (
    output cs_n,
    output sclk,
    output din,
    input dout_line
  );
endinterface

// >>> verilog/adc_port_device.sv
// The APB register port and the placing of the registers were decided locally.
`include "adc_port_consts.svh"

module adc_port_device (
  // clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic en_in,
  // serial link
  adc_link_if.dev link,
  // converter side
  input wire logic [12:0] conv_in,
  output logic [11:0] ctrl_out,
  output logic [6:0] seq_out,
  output logic [6:0] range_out,
  output logic [1:0] chan_out,
  output logic hold_out,
  output logic abort_out
);

  adc_port_pkg::dev_regs_type r;
  adc_port_pkg::dev_regs_type n;

  // true when a command names the target with its write bit set
  function automatic logic sel_hit(input logic [2:0] sel,
                                   input logic we,
                                   input logic [2:0] target);
    sel_hit = we && (sel == target);
  endfunction

  logic sclk_fall;
  logic sclk_rise;
  logic cs_fall;
  logic cs_rise;
  logic [10:0] head;

  // next-state logic
  always_comb begin
    n = r;
    n.abort = 1'b0;
    // three-stage sampling; a level counts once stages two and three agree
    n.sclk_sync = {r.sclk_sync[1:0], link.sclk};
    n.cs_sync = {r.cs_sync[1:0], link.cs_n};
    n.din_sync = {r.din_sync[1:0], link.din};
    if (r.sclk_sync[1] == r.sclk_sync[2]) begin
      n.sclk_f = r.sclk_sync[2];
    end
    if (r.cs_sync[1] == r.cs_sync[2]) begin
      n.cs_f = r.cs_sync[2];
    end
    if (r.din_sync[1] == r.din_sync[2]) begin
      n.din_f = r.din_sync[2];
    end
    // serial clock edges pace everything, no free-running timers
    sclk_fall = r.sclk_f & ~n.sclk_f;
    sclk_rise = ~r.sclk_f & n.sclk_f;
    cs_fall = r.cs_f & ~n.cs_f;
    cs_rise = ~r.cs_f & n.cs_f;
    // first eleven received bits, including the one arriving now
    head = {r.rx[9:0], n.din_f};
    case (r.state)
      adc_port_pkg::D_IDLE: begin
        if (cs_fall) begin
          n.state = adc_port_pkg::D_FRAME;
          n.hold = 1'b1;
          n.dout_oe = 1'b1;
          n.rise_cnt = 5'h00;
          n.fall_cnt = 5'h00;
          // input is frozen by the hold, so the word is captured here
          n.tx = {1'b0, r.ctrl[`CHAN_HI:`CHAN_LO], conv_in};
          n.dout = 1'b0;
        end
      end
      adc_port_pkg::D_FRAME: begin
        if (cs_rise) begin
          // loads already past stay, later ones never happen
          n.abort = (r.fall_cnt < `FRAME_EDGES);
          n.dout_oe = 1'b0;
          n.hold = 1'b0;
          n.state = adc_port_pkg::D_IDLE;
        end else begin
          if (sclk_fall && (r.fall_cnt < `FRAME_EDGES)) begin
            n.rx = {r.rx[14:0], n.din_f};
            n.fall_cnt = r.fall_cnt + 5'h01;
            if (n.fall_cnt == `FRAME_EDGES) begin
              n.dout_oe = 1'b0;
              n.dout = 1'b0;
            end else begin
              n.dout = r.tx[14];
              n.tx = {r.tx[14:0], 1'b0};
            end
            if (n.fall_cnt == `SR_LOAD_FALL) begin
              // head[10:8] select, head[7] write, head[6:0] value
              if (sel_hit(head[10:8], head[7], `SEL_SEQ)) begin
                n.seq = head[6:0];
              end
              if (sel_hit(head[10:8], head[7], `SEL_RANGE)) begin
                n.rng = head[6:0];
              end
            end
          end
          if (sclk_rise && (r.rise_cnt < `FRAME_EDGES)) begin
            n.rise_cnt = r.rise_cnt + 5'h01;
            if (n.rise_cnt == `TRACK_RISE) begin
              n.hold = 1'b0;
            end
            // only fifteen bits are in, so the lowest control bit
            // cannot be reached and keeps its value
            if ((n.rise_cnt == `CTRL_LOAD_RISE) &&
                sel_hit(r.rx[14:12], r.rx[11], `SEL_CTRL)) begin
              n.ctrl = {r.rx[10:0], r.ctrl[0]};
            end
          end
        end
      end
      default: begin
        n.state = adc_port_pkg::D_IDLE;
        n.dout_oe = 1'b0;
        n.hold = 1'b0;
      end
    endcase
  end

  // state register; enable low freezes everything
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r.sclk_sync <= 3'h7;
      r.cs_sync <= 3'h7;
      r.din_sync <= 3'h0;
      r.sclk_f <= 1'b1;
      r.cs_f <= 1'b1;
      r.din_f <= 1'b0;
      r.state <= adc_port_pkg::D_IDLE;
      r.rise_cnt <= 5'h00;
      r.fall_cnt <= 5'h00;
      r.rx <= 16'h0000;
      r.tx <= 16'h0000;
      r.dout <= 1'b0;
      r.dout_oe <= 1'b0;
      r.hold <= 1'b0;
      r.abort <= 1'b0;
      r.ctrl <= `CTRL_RESET;
      r.seq <= `SR_RESET;
      r.rng <= `SR_RESET;
    end else if (en_in) begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign link.dout = r.dout;
  assign link.dout_oe = r.dout_oe;
  assign ctrl_out = r.ctrl;
  assign seq_out = r.seq;
  assign range_out = r.rng;
  assign chan_out = r.ctrl[`CHAN_HI:`CHAN_LO];
  assign hold_out = r.hold;
  assign abort_out = r.abort;

endmodule

// >>> verilog/adc_port_host.sv
`include "adc_port_consts.svh"

module adc_port_host #(
  parameter int SCLK_HALF = `SCLK_HALF
) (
  // clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic en_in,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // serial link
  adc_link_if.host link
);

  localparam int PERIOD = 2 * SCLK_HALF;
  localparam int QP_RAW = (`QUIET_CYC + PERIOD - 1) / PERIOD;
  localparam logic [7:0] QUIET_PER = 8'(QP_RAW < 1 ? 1 : QP_RAW);
  localparam logic [7:0] HALF_END = 8'(SCLK_HALF - 1);
  localparam logic [7:0] PER_END = 8'(PERIOD - 1);

  adc_port_pkg::host_regs_type r;
  adc_port_pkg::host_regs_type n;
  logic access;
  logic idle;

  // next-state logic
  always_comb begin
    n = r;
    n.dout_sync = {r.dout_sync[1:0], link.dout_line};
    if (r.dout_sync[1] == r.dout_sync[2]) begin
      n.dout_f = r.dout_sync[2];
    end
    idle = (r.state == adc_port_pkg::H_IDLE);
    access = psel && penable && !r.pready;
    // bus: one wait cycle, then pready for one cycle
    n.pready = access;
    n.pslverr = 1'b0;
    n.prdata = 32'h0000_0000;
    if (access) begin
      case (paddr)
        `CMD_OFS: begin
          if (pwrite && idle) begin
            n.state = adc_port_pkg::H_FRAME;
            n.cs_n = 1'b0;
            n.sclk = 1'b1;
            n.div = 8'h00;
            n.bit_cnt = 5'h00;
            n.cmd = pwdata[15:0];
            n.din = pwdata[15];
          end
        end
        `RXD_OFS: n.prdata = {16'h0000, r.rxd};
        `STAT_OFS: begin
          n.prdata = {30'h0, r.done, !idle};
          if (pwrite && pwdata[`STAT_DONE]) begin
            n.done = 1'b0;
          end
        end
        default: n.pslverr = 1'b1;
      endcase
    end
    // link sequencing
    case (r.state)
      adc_port_pkg::H_IDLE: begin
      end
      adc_port_pkg::H_FRAME: begin
        n.div = r.div + 8'h01;
        if (r.div == HALF_END) begin
          n.div = 8'h00;
          if (r.sclk) begin
            n.sclk = 1'b0;
            // take the freshly agreed level: the leading zero only
            // settles in the same cycle as the first fall
            n.rx = {r.rx[14:0], n.dout_f};
            n.bit_cnt = r.bit_cnt + 5'h01;
          end else begin
            n.sclk = 1'b1;
            if (r.bit_cnt == `FRAME_EDGES) begin
              n.cs_n = 1'b1;
              n.rxd = r.rx;
              n.done = 1'b1; // set wins over clear
              n.quiet = QUIET_PER;
              n.state = adc_port_pkg::H_QUIET;
            end else begin
              n.din = r.cmd[14];
              n.cmd = {r.cmd[14:0], 1'b0};
            end
          end
        end
      end
      adc_port_pkg::H_QUIET: begin
        // whole clock periods only, so frames stay equidistant
        n.div = r.div + 8'h01;
        if (r.div == PER_END) begin
          n.div = 8'h00;
          n.quiet = r.quiet - 8'h01;
          if (r.quiet == 8'h01) begin
            n.state = adc_port_pkg::H_IDLE;
          end
        end
      end
      default: begin
        n.state = adc_port_pkg::H_IDLE;
        n.cs_n = 1'b1;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r.dout_sync <= 3'h7;
      r.dout_f <= 1'b1;
      r.state <= adc_port_pkg::H_IDLE;
      r.div <= 8'h00;
      r.quiet <= 8'h00;
      r.sclk <= 1'b1;
      r.cs_n <= 1'b1;
      r.din <= 1'b0;
      r.bit_cnt <= 5'h00;
      r.cmd <= 16'h0000;
      r.rx <= 16'h0000;
      r.rxd <= 16'h0000;
      r.done <= 1'b0;
      r.pready <= 1'b0;
      r.pslverr <= 1'b0;
      r.prdata <= 32'h0000_0000;
    end else if (en_in) begin
      r <= n;
    end
  end

  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign prdata = r.prdata;
  assign link.cs_n = r.cs_n;
  assign link.sclk = r.sclk;
  assign link.din = r.din;

endmodule

// >>> tb/adc_port_sva.sv
module adc_port_sva (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // link signals
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] falls_reg;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  // falls of the serial clock in this frame, cleared when deselected
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      falls_reg <= 5'h00;
    else if (cs_n)
      falls_reg <= 5'h00;
    else if ($fell(sclk))
      falls_reg <= falls_reg + 5'h01;
  end
  // sync latency of the device allows a few cycles
  sequence zero_out_s;
    ##[1:8] (dout_oe && !dout);
  endsequence
  sequence quiet_s;
    cs_n [*8];
  endsequence
  start_zero_a: assert property ($fell(cs_n) |-> zero_out_s)
    else $error("zero bit not driven");
  oe_select_a: assert property ($rose(dout_oe) |-> !cs_n)
    else $error("output driven while deselected");
  oe_held_a: assert property (
    !cs_n && falls_reg != 5'h10 && $past(dout_oe) |-> dout_oe)
    else $error("output released early");
  oe_release_a: assert property (
    $changed(falls_reg) && falls_reg == 5'h10 |-> ##[1:8] !dout_oe)
    else $error("output not released");
  frame_len_a: assert property ($rose(cs_n) |-> falls_reg == 5'h10)
    else $error("frame not sixteen clocks");
  dout_fall_a: assert property (
    sclk && $past(sclk) && dout_oe && $past(dout_oe) |-> $stable(dout))
    else $error("output moved while clock high");
  din_steady_a: assert property (
    !sclk && !cs_n && !$past(cs_n) |-> $stable(din))
    else $error("input moved while clock low");
  idle_clock_a: assert property (cs_n && $past(cs_n) |-> sclk)
    else $error("clock moved outside frame");
  quiet_gap_a: assert property ($rose(cs_n) |-> quiet_s)
    else $error("quiet time too short");
endmodule

// >>> tb/tb_top.sv
`include "adc_port_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, perr, hold, abort, abort2;
  logic [12:0] conv = 13'h0000;
  logic [11:0] ctrl, ctrl_exp;
  logic [6:0] seq, rng, rng2, seq_exp, rng_exp;
  logic [1:0] chan;
  logic cs2 = 1'b1, s2 = 1'b1, d2 = 1'b0;
  int ab_count = 0;
  logic [15:0] r = 16'h0027, cmd;
  logic [2:0] sels [4] = '{`SEL_CTRL, `SEL_RANGE, `SEL_SEQ, 3'h2};
  int n_errors = 0, n_checks = 0;
  adc_link_if link();
  adc_link_if link2();
  always #5 clk = ~clk;
  adc_port_host u_adc_port_host (.ref_clk_in(clk), .arst_n_in(arst_n),
    .en_in(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .link(link.host));
  adc_port_device u_adc_port_device (.ref_clk_in(clk), .arst_n_in(arst_n),
    .en_in(1'b1), .link(link.dev), .conv_in(conv), .ctrl_out(ctrl),
    .seq_out(seq), .range_out(rng), .chan_out(chan), .hold_out(hold),
    .abort_out(abort));
  // second device faces a bench driver that cuts frames short
  adc_port_device u_adc_port_device_b (.ref_clk_in(clk), .arst_n_in(arst_n),
    .en_in(1'b1), .link(link2.dev), .conv_in(conv), .ctrl_out(),
    .seq_out(), .range_out(rng2), .chan_out(), .hold_out(),
    .abort_out(abort2));
  adc_port_sva u_sva (.ref_clk_in(clk), .arst_n_in(arst_n), .cs_n(link.cs_n),
    .sclk(link.sclk), .din(link.din), .dout(link.dout),
    .dout_oe(link.dout_oe));
  assign link2.cs_n = cs2;
  assign link2.sclk = s2;
  assign link2.din = d2;
  // abort is a one-cycle pulse, so count every pulse
  always @(posedge clk) if (abort2) ab_count <= ab_count + 1;

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [31:0] exp_word(input logic [1:0] c,
                                           input logic [12:0] v);
    return {16'h0000, 1'b0, c, v};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // n falls at 160 ns period, then chip select rises early
  task automatic frame2(input logic [15:0] w, input int n);
    @(posedge clk);
    cs2 <= 1'b0;
    d2 <= w[15];
    for (int k = 0; k < n; k++) begin
      repeat (8) @(posedge clk);
      s2 <= 1'b0;
      repeat (8) @(posedge clk);
      s2 <= 1'b1;
      w = w << 1;
      d2 <= (k == n - 1) ? ~d2 : w[15];
    end
    cs2 <= 1'b1;
    repeat (16) @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    ctrl_exp = 12'h000;
    seq_exp = 7'h00;
    rng_exp = 7'h00;
    for (int i = 0; i < 12; i++) begin
      r = lfsr(r);
      conv <= r[12:0];
      r = lfsr(r);
      cmd = r;
      cmd[15:13] = sels[i % 4];
      if (i < 4)
        cmd[12] = 1'b1;
      apb(1'b1, `CMD_OFS, {16'h0000, cmd}, q);
      // a second command while busy must be dropped
      if (i == 5)
        apb(1'b1, `CMD_OFS, {16'h0000, ~cmd}, q);
      do apb(1'b0, `STAT_OFS, 32'h0, q); while (q[0] === 1'b1);
      chk(q[1], 1'b1);
      apb(1'b0, `RXD_OFS, 32'h0, q);
      chk(q, exp_word(ctrl_exp[11:10], conv));
      if (cmd[12] && cmd[15:13] == `SEL_CTRL)
        ctrl_exp = {cmd[11:1], 1'b0};
      if (cmd[12] && cmd[15:13] == `SEL_RANGE)
        rng_exp = cmd[11:5];
      if (cmd[12] && cmd[15:13] == `SEL_SEQ)
        seq_exp = cmd[11:5];
      chk({ctrl, seq, rng}, {ctrl_exp, seq_exp, rng_exp});
      chk({chan, hold, abort}, {ctrl_exp[11:10], 2'b00});
      apb(1'b1, `STAT_OFS, 32'h2, q);
    end
    apb(1'b0, `STAT_OFS, 32'h0, q);
    chk(q[1:0], 2'b00);
    apb(1'b0, 8'h0c, 32'h0, q);
    chk({q, perr}, {32'h0, 1'b1});
    frame2(16'h3aa0, 8);
    chk({ab_count == 1, link2.dout_oe, rng2}, {2'b10, 7'h00});
    frame2(16'h3aa0, 12);
    chk({ab_count == 2, link2.dout_oe, rng2}, {2'b10, 7'h55});
    complete_run();
  end
endmodule
